// file: hw/i2cm_core.sv
// Purpose: I2C master sequencer, general call receiver and clock release.
// Assumes: Configuration inputs are quasi-static; commands are pulses.
// Notes: Pins and bus sequencing live on link_clk_i, flags on clk_i.
// What this block does
// - With stretch enable set, clock hold waits until the clock is low.
// - Clearing the clock release bit forces the clock output low.
// - Clock stays low until release bit set and all others release it.
// - With stretch enable clear, clearing release bit holds clock low at once.
// - An all-zero address byte with write bit is the general call.
// - General call is recognised only while general call enable is set.
// - After a start, eight bits are shifted and compared to both addresses.
// - General call loads buffer, sets full at bit eight, interrupt on ninth.
// - General call in ten-bit mode sets no update flag, goes straight to data.
// - Start-seen and stop-seen flags clear on reset and module disable.
// - No queueing: buffer write during an operation is dropped, collision set.
// - Master sets interrupt flag after start, stop, byte, ack, repeated start.
// - Transmitter sends address with write bit, then bytes, receiving acks.
// - Receiver sends address with read bit, receives bytes, sends acks.
// - Repeated start keeps the bus owned and opens the next transfer.
// - After a sent byte the slave ack is stored, interrupt after ninth clock.
// - Start and stop are commanded; interrupt once stop has finished.
// - Baud reload is the low seven address bits; buffer write starts counting.
// - Baud counter counts down to zero and stops until reloaded.
// - Baud counter decrements on both Q2 and Q4 of each instruction cycle.
// - After an operation the counter stops and the clock keeps its level.
// - One clock period is two baud rollovers, low phase and high phase.
module i2cm_core (
  // System clock and reset.
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Link clock for the pin-facing logic.
  input wire logic link_clk_i,
  // Bus pins.
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Configuration.
  input wire logic port_enable_i,
  input wire logic [3:0] port_mode_select_i,
  input wire logic general_call_enable_i,
  input wire logic start_stretch_enable_i,
  input wire logic clock_release_bit_i,
  input wire logic [7:0] address_baud_register_i,
  input wire logic address_write_i,
  input wire logic ack_data_i,
  // Commands.
  input wire logic start_cmd_i,
  input wire logic rstart_cmd_i,
  input wire logic stop_cmd_i,
  input wire logic recv_cmd_i,
  input wire logic ack_cmd_i,
  input wire logic buffer_write_i,
  input wire logic [7:0] buffer_wdata_i,
  input wire logic buffer_read_i,
  // Flag clears.
  input wire logic serial_int_clr_i,
  input wire logic write_collision_clr_i,
  // Status.
  output logic [7:0] serial_buffer_register_o,
  output logic buffer_full_flag_o,
  output logic serial_interrupt_flag_o,
  output logic write_collision_flag_o,
  output logic ack_status_o,
  output logic address_update_flag_o,
  output logic start_seen_o,
  output logic stop_seen_o,
  output logic busy_o
);

  typedef struct packed {
    logic cmd_tgl;
    i2cm_pkg::i2cm_cmd_t cmd;
    logic [7:0] wdata;
    logic busy;
    logic [3:0] ev1;
    logic [3:0] ev2;
    logic [3:0] ev3;
    logic [2:0] st1;
    logic [2:0] st2;
    logic [7:0] buf_data;
    logic bf;
    logic sif;
    logic write_collision_flag;
    logic ua;
  } i2cm_sys_t;

  typedef struct packed {
    logic c1;
    logic c2;
    logic c3;
    logic [i2cm_pkg::CFG_W-1:0] cf1;
    logic [i2cm_pkg::CFG_W-1:0] cf2;
    logic [1:0] pn1;
    logic [1:0] pn2;
    logic [1:0] pn3;
    logic [1:0] ph;
    logic [6:0] baud_counter;
    i2cm_pkg::i2cm_mst_t mst;
    i2cm_pkg::i2cm_cmd_t op;
    logic [8:0] sh;
    logic [8:0] cap;
    logic [3:0] bits;
    logic scl_oe;
    logic sda_oe;
    logic hold;
    i2cm_pkg::i2cm_slv_t slv;
    logic [3:0] sbits;
    logic [7:0] ssh;
    logic s;
    logic p;
    logic [3:0] ev;
    logic ackstat;
    logic [7:0] rx;
  } i2cm_lnk_t;

  i2cm_sys_t sq;
  i2cm_sys_t sd;
  i2cm_lnk_t lq;
  i2cm_lnk_t ld;

  logic sys_master;
  logic [3:0] ev_edge;
  logic en;
  logic mst_en;
  logic slv_en;
  logic ten_bit;
  logic clock_release_bit;
  logic start_stretch_enable;
  logic general_call_enable;
  logic scl_s;
  logic sda_s;
  logic rise;
  logic fall;
  logic tick;
  logic new_cmd;
  logic [6:0] reload;
  logic [7:0] own_addr;
  logic [7:0] sbyte;
  logic own_hit;
  logic gc_hit;

  // System side: commands, collision check and software-visible flags.
  assign sys_master = port_enable_i
                      && port_mode_select_i == i2cm_pkg::MODE_MASTER;
  assign ev_edge = sq.ev2 ^ sq.ev3;

  always_comb begin
    sd = sq;
    sd.ev1 = lq.ev;
    sd.ev2 = sq.ev1;
    sd.ev3 = sq.ev2;
    sd.st1 = {lq.ackstat, lq.s, lq.p};
    sd.st2 = sq.st1;
    if (serial_int_clr_i) begin
      sd.sif = 1'b0;
    end
    if (write_collision_clr_i) begin
      sd.write_collision_flag = 1'b0;
    end
    if (buffer_read_i) begin
      sd.bf = 1'b0;
    end
    if (address_write_i) begin
      sd.ua = 1'b0;
    end
    if (buffer_write_i && sq.busy) begin
      sd.write_collision_flag = 1'b1;
    end else if (buffer_write_i) begin
      sd.buf_data = buffer_wdata_i;
    end
    if (sys_master && !sq.busy) begin
      sd.cmd = i2cm_pkg::CMD_NONE;
      if (start_cmd_i) begin
        sd.cmd = i2cm_pkg::CMD_START;
      end else if (rstart_cmd_i) begin
        sd.cmd = i2cm_pkg::CMD_RSTART;
      end else if (stop_cmd_i) begin
        sd.cmd = i2cm_pkg::CMD_STOP;
      end else if (recv_cmd_i) begin
        sd.cmd = i2cm_pkg::CMD_RX;
      end else if (ack_cmd_i) begin
        sd.cmd = i2cm_pkg::CMD_ACK;
      end else if (buffer_write_i) begin
        sd.cmd = i2cm_pkg::CMD_TX;
        sd.wdata = buffer_wdata_i;
      end
      if (sd.cmd != i2cm_pkg::CMD_NONE) begin
        sd.cmd_tgl = ~sq.cmd_tgl;
        sd.busy = 1'b1;
      end else begin
        sd.cmd = sq.cmd;
      end
    end
    if (ev_edge[i2cm_pkg::EV_DONE] || !port_enable_i) begin
      sd.busy = 1'b0;
    end
    if (ev_edge[i2cm_pkg::EV_INT]) begin
      sd.sif = 1'b1;
    end
    if (ev_edge[i2cm_pkg::EV_LOAD]) begin
      sd.bf = 1'b1;
      sd.buf_data = lq.rx;
    end
    if (ev_edge[i2cm_pkg::EV_UA]) begin
      sd.ua = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sq <= '0;
    end else begin
      sq <= sd;
    end
  end

  // Link side decode from synchronised configuration and pins.
  assign en = lq.cf2[i2cm_pkg::CFG_EN];
  assign mst_en = en && lq.cf2[i2cm_pkg::CFG_MODE_HI:i2cm_pkg::CFG_MODE_LO]
                  == i2cm_pkg::MODE_MASTER;
  assign ten_bit = lq.cf2[i2cm_pkg::CFG_MODE_HI:i2cm_pkg::CFG_MODE_LO]
                   == i2cm_pkg::MODE_SLAVE10;
  assign slv_en = en && (ten_bit
                  || lq.cf2[i2cm_pkg::CFG_MODE_HI:i2cm_pkg::CFG_MODE_LO]
                  == i2cm_pkg::MODE_SLAVE7);
  assign clock_release_bit = lq.cf2[i2cm_pkg::CFG_CKP];
  assign start_stretch_enable = lq.cf2[i2cm_pkg::CFG_SEN];
  assign general_call_enable = lq.cf2[i2cm_pkg::CFG_GENERAL_CALL_ENABLE];
  assign own_addr = lq.cf2[i2cm_pkg::CFG_ADDR_HI:0];
  assign reload = own_addr[6:0];
  assign scl_s = lq.pn2[1];
  assign sda_s = lq.pn2[0];
  assign rise = scl_s && !lq.pn3[1];
  assign fall = !scl_s && lq.pn3[1];
  assign tick = lq.ph == i2cm_pkg::PH_Q2 || lq.ph == i2cm_pkg::PH_Q4;
  assign new_cmd = lq.c2 ^ lq.c3;
  assign sbyte = {lq.ssh[6:0], sda_s};
  assign gc_hit = general_call_enable && sbyte == i2cm_pkg::GC_ADDR;
  assign own_hit = sbyte[7:1] == own_addr[7:1] && !sbyte[0];

  always_comb begin
    ld = lq;
    ld.c1 = sq.cmd_tgl;
    ld.c2 = lq.c1;
    ld.c3 = lq.c2;
    ld.cf1 = {port_enable_i, port_mode_select_i, general_call_enable_i,
              start_stretch_enable_i, clock_release_bit_i, ack_data_i,
              address_baud_register_i};
    ld.cf2 = lq.cf1;
    ld.pn1 = {scl_i, sda_i};
    ld.pn2 = lq.pn1;
    ld.pn3 = lq.pn2;
    ld.ph = lq.ph + 2'h1;
    if (lq.mst != i2cm_pkg::M_IDLE && tick && lq.baud_counter != 7'h00) begin
      ld.baud_counter = lq.baud_counter - 7'h01;
    end
    if (scl_s && lq.pn3[1] && lq.pn3[0] && !sda_s) begin
      ld.s = 1'b1;
      ld.p = 1'b0;
    end
    if (scl_s && lq.pn3[1] && !lq.pn3[0] && sda_s) begin
      ld.p = 1'b1;
      ld.s = 1'b0;
    end
    if (mst_en) begin
      ld.hold = 1'b0;
      case (lq.mst)
        i2cm_pkg::M_IDLE: begin
          if (new_cmd) begin
            ld.op = sq.cmd;
            ld.baud_counter = reload;
            ld.cap = '0;
            case (sq.cmd)
              i2cm_pkg::CMD_START: begin
                ld.scl_oe = 1'b0;
                ld.sda_oe = 1'b0;
                ld.mst = i2cm_pkg::M_START1;
              end
              i2cm_pkg::CMD_RSTART: begin
                ld.scl_oe = 1'b1;
                ld.mst = i2cm_pkg::M_RS1;
              end
              i2cm_pkg::CMD_STOP: begin
                ld.scl_oe = 1'b1;
                ld.sda_oe = 1'b1;
                ld.mst = i2cm_pkg::M_STOP1;
              end
              i2cm_pkg::CMD_TX: begin
                ld.sh = {sq.wdata, 1'b1};
                ld.bits = i2cm_pkg::BITS_TX;
                ld.scl_oe = 1'b1;
                ld.mst = i2cm_pkg::M_LOW;
              end
              i2cm_pkg::CMD_RX: begin
                ld.sh = 9'h1ff;
                ld.bits = i2cm_pkg::BITS_RX;
                ld.scl_oe = 1'b1;
                ld.mst = i2cm_pkg::M_LOW;
              end
              i2cm_pkg::CMD_ACK: begin
                ld.sh = {lq.cf2[i2cm_pkg::CFG_ACKDT], 8'hff};
                ld.bits = i2cm_pkg::BITS_ACK;
                ld.scl_oe = 1'b1;
                ld.mst = i2cm_pkg::M_LOW;
              end
              default: begin
                ld.ev[i2cm_pkg::EV_DONE] = ~lq.ev[i2cm_pkg::EV_DONE];
              end
            endcase
          end
        end
        i2cm_pkg::M_START1: begin
          if (lq.baud_counter == 7'h00) begin
            ld.sda_oe = 1'b1;
            ld.baud_counter = reload;
            ld.mst = i2cm_pkg::M_START2;
          end
        end
        i2cm_pkg::M_START2, i2cm_pkg::M_STOP3: begin
          if (lq.baud_counter == 7'h00) begin
            ld.ev[i2cm_pkg::EV_INT] = ~lq.ev[i2cm_pkg::EV_INT];
            ld.ev[i2cm_pkg::EV_DONE] = ~lq.ev[i2cm_pkg::EV_DONE];
            ld.mst = i2cm_pkg::M_IDLE;
          end
        end
        i2cm_pkg::M_RS1, i2cm_pkg::M_STOP1: begin
          if (lq.baud_counter == 7'h00) begin
            ld.scl_oe = 1'b0;
            ld.baud_counter = reload;
            ld.mst = lq.mst == i2cm_pkg::M_RS1 ? i2cm_pkg::M_RS2
                                               : i2cm_pkg::M_STOP2;
          end
        end
        i2cm_pkg::M_RS2, i2cm_pkg::M_STOP2: begin
          if (!scl_s) begin
            ld.baud_counter = reload;
          end else if (lq.baud_counter == 7'h00) begin
            ld.sda_oe = lq.mst == i2cm_pkg::M_RS2;
            ld.baud_counter = reload;
            ld.mst = lq.mst == i2cm_pkg::M_RS2 ? i2cm_pkg::M_START2
                                               : i2cm_pkg::M_STOP3;
          end
        end
        i2cm_pkg::M_LOW: begin
          ld.sda_oe = !lq.sh[8];
          if (lq.baud_counter == 7'h00) begin
            ld.scl_oe = 1'b0;
            ld.baud_counter = reload;
            ld.mst = i2cm_pkg::M_HIGH;
          end
        end
        i2cm_pkg::M_HIGH: begin
          if (!scl_s) begin
            ld.baud_counter = reload;
          end else if (lq.baud_counter == 7'h00) begin
            ld.cap = {lq.cap[7:0], sda_s};
            ld.sh = {lq.sh[7:0], 1'b1};
            ld.bits = lq.bits - 4'h1;
            ld.scl_oe = 1'b1;
            ld.baud_counter = reload;
            ld.mst = i2cm_pkg::M_LOW;
            if (lq.bits == 4'h1) begin
              ld.mst = i2cm_pkg::M_IDLE;
              ld.ev[i2cm_pkg::EV_INT] = ~lq.ev[i2cm_pkg::EV_INT];
              ld.ev[i2cm_pkg::EV_DONE] = ~lq.ev[i2cm_pkg::EV_DONE];
              if (lq.op == i2cm_pkg::CMD_TX) begin
                ld.ackstat = sda_s;
              end
              if (lq.op == i2cm_pkg::CMD_RX) begin
                ld.rx = {lq.cap[6:0], sda_s};
                ld.ev[i2cm_pkg::EV_LOAD] = ~lq.ev[i2cm_pkg::EV_LOAD];
              end
            end
          end
        end
        default: begin
          ld.mst = i2cm_pkg::M_IDLE;
        end
      endcase
    end else if (slv_en) begin
      ld.mst = i2cm_pkg::M_IDLE;
      if (clock_release_bit) begin
        ld.hold = 1'b0;
      end else if (!start_stretch_enable || !scl_s) begin
        ld.hold = 1'b1;
      end
      ld.scl_oe = ld.hold;
      case (lq.slv)
        i2cm_pkg::S_ADDR, i2cm_pkg::S_DATA: begin
          if (rise) begin
            ld.ssh = sbyte;
            ld.sbits = lq.sbits + 4'h1;
            if (lq.sbits == 4'h7) begin
              ld.sbits = i2cm_pkg::BITS_BYTE;
              ld.slv = i2cm_pkg::S_ACK;
              ld.rx = sbyte;
              if (lq.slv == i2cm_pkg::S_DATA || gc_hit || own_hit) begin
                ld.ev[i2cm_pkg::EV_LOAD] = ~lq.ev[i2cm_pkg::EV_LOAD];
              end else begin
                ld.slv = i2cm_pkg::S_IDLE;
              end
              if (lq.slv == i2cm_pkg::S_ADDR && ten_bit && own_hit
                  && !gc_hit) begin
                ld.ev[i2cm_pkg::EV_UA] = ~lq.ev[i2cm_pkg::EV_UA];
              end
            end
          end
        end
        i2cm_pkg::S_ACK: begin
          if (fall && lq.sbits == i2cm_pkg::BITS_BYTE) begin
            ld.sda_oe = 1'b1;
            ld.sbits = i2cm_pkg::BITS_TX;
          end else if (fall) begin
            ld.sda_oe = 1'b0;
            ld.ev[i2cm_pkg::EV_INT] = ~lq.ev[i2cm_pkg::EV_INT];
            ld.sbits = 4'h0;
            ld.slv = i2cm_pkg::S_DATA;
          end
        end
        default: begin
          ld.sda_oe = 1'b0;
        end
      endcase
      if (scl_s && lq.pn3[1] && lq.pn3[0] && !sda_s) begin
        ld.slv = i2cm_pkg::S_ADDR;
        ld.sbits = 4'h0;
        ld.sda_oe = 1'b0;
      end
      if (scl_s && lq.pn3[1] && !lq.pn3[0] && sda_s) begin
        ld.slv = i2cm_pkg::S_IDLE;
        ld.sda_oe = 1'b0;
      end
    end
    if (!en) begin
      ld.s = 1'b0;
      ld.p = 1'b0;
      ld.mst = i2cm_pkg::M_IDLE;
      ld.slv = i2cm_pkg::S_IDLE;
      ld.scl_oe = 1'b0;
      ld.sda_oe = 1'b0;
      ld.hold = 1'b0;
    end
  end

  always_ff @(posedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lq <= '0;
    end else begin
      lq <= ld;
    end
  end

  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = lq.scl_oe;
  assign sda_oe_o = lq.sda_oe;
  assign serial_buffer_register_o = sq.buf_data;
  assign buffer_full_flag_o = sq.bf;
  assign serial_interrupt_flag_o = sq.sif;
  assign write_collision_flag_o = sq.write_collision_flag;
  assign ack_status_o = sq.st2[2];
  assign address_update_flag_o = sq.ua;
  assign start_seen_o = sq.st2[1];
  assign stop_seen_o = sq.st2[0];
  assign busy_o = sq.busy;

  sequence stop_last_s;
    lq.mst == i2cm_pkg::M_STOP3 && lq.baud_counter == 7'h00;
  endsequence

  sequence int_toggled_s;
    lq.ev[i2cm_pkg::EV_INT] != $past(lq.ev[i2cm_pkg::EV_INT])
      && lq.mst == i2cm_pkg::M_IDLE;
  endsequence

  write_collision_flag_set_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    buffer_write_i && sq.busy |=> sq.write_collision_flag)
    else $error("write during operation did not set collision flag");

  write_drop_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    buffer_write_i && sq.busy |=> $stable(sq.cmd_tgl) && $stable(sq.wdata))
    else $error("write during operation was not discarded");

  int_flag_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    ev_edge[i2cm_pkg::EV_INT] |=> sq.sif)
    else $error("event did not set interrupt flag");

  flags_clr_a: assert property (
    @(posedge link_clk_i) disable iff (!reset_n_i)
    !en |=> !lq.s && !lq.p)
    else $error("start or stop flag survived disable");

  stretch_now_a: assert property (
    @(posedge link_clk_i) disable iff (!reset_n_i)
    slv_en && !clock_release_bit && !start_stretch_enable |=> lq.scl_oe)
    else $error("clock not held low at once");

  stretch_wait_a: assert property (
    @(posedge link_clk_i) disable iff (!reset_n_i)
    slv_en && !clock_release_bit && start_stretch_enable && scl_s && !lq.hold |=> !lq.scl_oe)
    else $error("clock pulled low before it was sampled low");

  brg_stop_a: assert property (
    @(posedge link_clk_i) disable iff (!reset_n_i)
    mst_en && lq.mst == i2cm_pkg::M_IDLE && !new_cmd |=> $stable(lq.baud_counter))
    else $error("baud counter moved while idle");

  brg_phase_a: assert property (
    @(posedge link_clk_i) disable iff (!reset_n_i)
    mst_en && lq.mst == i2cm_pkg::M_LOW && !tick && lq.baud_counter != 7'h00
      |=> lq.baud_counter == $past(lq.baud_counter))
    else $error("baud counter moved outside Q2 and Q4");

  stop_int_a: assert property (
    @(posedge link_clk_i) disable iff (!reset_n_i)
    stop_last_s and (mst_en && en) |=> int_toggled_s)
    else $error("stop completion raised no interrupt");

  gc_load_a: assert property (
    @(posedge link_clk_i) disable iff (!reset_n_i)
    slv_en && lq.slv == i2cm_pkg::S_ADDR && rise && lq.sbits == 4'h7
      && gc_hit |=> lq.slv == i2cm_pkg::S_ACK
      && lq.rx == i2cm_pkg::GC_ADDR)
    else $error("general call byte not loaded");

endmodule : i2cm_core

// file: pkg/i2cm_pkg.sv
// Purpose: Shared constants and types for the serial port I2C core.
// Assumes: Bus pins are open drain; the link side runs on its own clock.
// Notes: Configuration bits travel to the link side as one packed vector.
package i2cm_pkg;

  // Port mode select codes.
  localparam logic [3:0] MODE_SLAVE7 = 4'h6;
  localparam logic [3:0] MODE_SLAVE10 = 4'h7;
  localparam logic [3:0] MODE_MASTER = 4'h8;

  // Fixed general call address byte.
  localparam logic [7:0] GC_ADDR = 8'h00;

  // Baud counter phases Q2 and Q4 within a four-clock instruction cycle.
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q4 = 2'h3;

  // Layout of the configuration vector sent to the link side.
  localparam int CFG_W = 17;
  localparam int CFG_EN = 16;
  localparam int CFG_MODE_HI = 15;
  localparam int CFG_MODE_LO = 12;
  localparam int CFG_GENERAL_CALL_ENABLE = 11;
  localparam int CFG_SEN = 10;
  localparam int CFG_CKP = 9;
  localparam int CFG_ACKDT = 8;
  localparam int CFG_ADDR_HI = 7;

  // Event toggle positions from link to system side.
  localparam int EV_INT = 0;
  localparam int EV_LOAD = 1;
  localparam int EV_UA = 2;
  localparam int EV_DONE = 3;

  // Bit counts of the master operations and of a slave byte.
  localparam logic [3:0] BITS_TX = 4'h9;
  localparam logic [3:0] BITS_RX = 4'h8;
  localparam logic [3:0] BITS_ACK = 4'h1;
  localparam logic [3:0] BITS_BYTE = 4'h8;

  typedef enum logic [2:0] {
    CMD_NONE, CMD_START, CMD_RSTART, CMD_STOP, CMD_TX, CMD_RX, CMD_ACK
  } i2cm_cmd_t;

  typedef enum logic [3:0] {
    M_IDLE, M_START1, M_START2, M_RS1, M_RS2, M_LOW, M_HIGH,
    M_STOP1, M_STOP2, M_STOP3
  } i2cm_mst_t;

  typedef enum logic [1:0] {S_IDLE, S_ADDR, S_ACK, S_DATA} i2cm_slv_t;

endpackage : i2cm_pkg

// file: bench/i2cm_peer.sv
// Purpose: Behavioural I2C slave that faces the master under test.
// Assumes: Open-drain lines with pull-ups; inputs are resolved levels.
// Notes: Acks address and written bytes, sends rd_byte_i on reads.
module i2cm_peer (
  // Bus.
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_oe_o,
  output logic sda_oe_o,
  // Control.
  input wire logic on_i,
  input wire logic slow_i,
  input wire logic [7:0] rd_byte_i
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cnt;
  logic [7:0] sh;
  logic first, rd, act;
  initial begin
    {scl_oe_o, sda_oe_o, cnt, sh, first, rd, act} = '0;
  end
  always @(negedge sda_i) begin
    if (scl_i && on_i) begin
      cnt = 4'h0;
      first = 1'h1;
      act = 1'h1;
    end
  end
  // A stop frees the bus.
  always @(posedge sda_i) begin
    if (scl_i) begin
      act = 1'h0;
      sda_oe_o = 1'h0;
    end
  end
  always @(posedge scl_i) begin
    sh = {sh[6:0], sda_i};
    cnt = cnt + 4'h1;
  end
  always @(negedge scl_i) begin
    if (act) begin
      if (cnt == 4'h8) begin
        rd = first ? sh[0] : rd;
        sda_oe_o = first || !rd;
      end else if (cnt == 4'h9) begin
        // A not-acknowledge from the master ends the read.
        act = !(rd && !first && sh[0]);
        cnt = 4'h0;
        first = 1'h0;
        sda_oe_o = act && rd && !rd_byte_i[7];
      end else begin
        sda_oe_o = rd && !first && !rd_byte_i[3'h7 - cnt[2:0]];
      end
      if (slow_i) begin
        fork
          begin
            scl_oe_o = 1'h1;
            #40 scl_oe_o = 1'h0;
          end
        join_none
      end
    end
  end
endmodule : i2cm_peer

// file: bench/i2cm_core_tb.sv
// Purpose: Self-checking bench for the I2C master and general call core.
// Assumes: Open-drain lines float high when nobody pulls them.
// Notes: The bench bit-bangs a foreign master for the slave-side cases.
module i2cm_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'h0, lclk = 1'h0, rst_n = 1'h0;
  logic en = 1'h0, gce = 1'h0, sse = 1'h0, crb = 1'h1, ackd = 1'h0;
  logic on = 1'h1, slow = 1'h0, ms = 1'h0, md = 1'h0;
  logic [3:0] mode = 4'h8;
  logic [7:0] abr = 8'h08, wd = 8'h00, buf_o;
  logic [9:0] cmd = '0;
  logic d_scl_oe, d_sda_oe, p_scl_oe, p_sda_oe, ack_st, sseen, pseen;
  logic full, intf, write_collision_flag, ua, busy;
  wire scl = !(d_scl_oe || p_scl_oe || ms);
  wire sda = !(d_sda_oe || p_sda_oe || md);
  int n_mismatch = 0, n_tests = 0;
  real t0 = 0.0, lo = 0.0, hi = 0.0;
  always #2.5 clk = ~clk;
  initial #1.3 forever #3 lclk = ~lclk;
  always @(scl) begin
    if (scl) lo = $realtime - t0;
    else hi = $realtime - t0;
    t0 = $realtime;
  end
  i2cm_core i2cm_core_i (
    .clk_i(clk), .reset_n_i(rst_n), .link_clk_i(lclk),
    .scl_i(scl), .scl_o(), .scl_oe_o(d_scl_oe),
    .sda_i(sda), .sda_o(), .sda_oe_o(d_sda_oe),
    .port_enable_i(en), .port_mode_select_i(mode),
    .general_call_enable_i(gce), .start_stretch_enable_i(sse),
    .clock_release_bit_i(crb), .address_baud_register_i(abr),
    .address_write_i(cmd[9]), .ack_data_i(ackd),
    .start_cmd_i(cmd[0]), .rstart_cmd_i(cmd[1]), .stop_cmd_i(cmd[2]),
    .recv_cmd_i(cmd[3]), .ack_cmd_i(cmd[4]), .buffer_write_i(cmd[5]),
    .buffer_wdata_i(wd), .buffer_read_i(cmd[6]),
    .serial_int_clr_i(cmd[7]), .write_collision_clr_i(cmd[8]),
    .serial_buffer_register_o(buf_o), .buffer_full_flag_o(full),
    .serial_interrupt_flag_o(intf), .write_collision_flag_o(write_collision_flag),
    .ack_status_o(ack_st), .address_update_flag_o(ua),
    .start_seen_o(sseen), .stop_seen_o(pseen), .busy_o(busy));
  i2cm_peer i2cm_peer_i (
    .scl_i(scl), .sda_i(sda), .scl_oe_o(p_scl_oe), .sda_oe_o(p_sda_oe),
    .on_i(on), .slow_i(slow), .rd_byte_i(8'h3c));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic pulse(input int b);
    @(posedge clk) cmd[b] <= 1'h1;
    @(posedge clk) cmd <= '0;
  endtask : pulse
  // Interrupt clear, then one command, then wait for it to finish.
  task automatic op(input int b);
    int k;
    pulse(7);
    pulse(b);
    repeat (2) @(posedge clk);
    for (k = 0; busy !== 1'h0 && k < 9999; k++) @(posedge clk);
    chk(busy, 1'h0);
    repeat (8) @(posedge clk);
  endtask : op
  task automatic t_master;
    chk(sseen, 1'h0);
    chk(pseen, 1'h0);
    @(posedge clk) en <= 1'h1;
    repeat (8) @(posedge clk);
    op(0);
    chk(intf, 1'h1);
    chk(sseen, 1'h1);
    wd <= 8'ha4;
    pulse(7);
    pulse(5);
    wd <= 8'hff;
    op(5);
    chk(write_collision_flag, 1'h1);
    chk(buf_o, 8'ha4);
    chk(ack_st, 1'h0);
    chk(intf, 1'h1);
    chk(d_scl_oe, 1'h1);
    chk(lo > 95.0 && lo < 110.0, 1'h1);
    chk(hi > 101.0 && hi < 145.0, 1'h1);
    op(1);
    chk(intf, 1'h1);
    chk(pseen, 1'h0);
    wd <= 8'ha5;
    op(5);
    chk(ack_st, 1'h0);
    slow <= 1'h1;
    op(3);
    chk(buf_o, 8'h3c);
    chk(full, 1'h1);
    chk(intf, 1'h1);
    pulse(6);
    ackd <= 1'h1;
    op(4);
    chk(intf, 1'h1);
    slow <= 1'h0;
    op(2);
    chk(intf, 1'h1);
    chk(pseen, 1'h1);
    @(posedge clk) en <= 1'h0;
    repeat (12) @(posedge clk);
    chk({sseen, pseen}, 2'h0);
    $display("master test done");
  endtask : t_master
  task automatic t_stretch;
    @(posedge clk) begin
      {mode, en, crb} <= {4'h6, 1'h1, 1'h0};
    end
    repeat (16) @(posedge clk);
    chk(d_scl_oe, 1'h1);
    crb <= 1'h1;
    repeat (16) @(posedge clk);
    chk(scl, 1'h1);
    sse <= 1'h1;
    repeat (16) @(posedge clk);
    crb <= 1'h0;
    repeat (16) @(posedge clk);
    chk(d_scl_oe, 1'h0);
    ms <= 1'h1;
    repeat (16) @(posedge clk);
    ms <= 1'h0;
    repeat (16) @(posedge clk);
    chk({d_scl_oe, scl}, 2'h2);
    crb <= 1'h1;
    sse <= 1'h0;
    repeat (16) @(posedge clk);
    chk(scl, 1'h1);
    $display("clock release test done");
  endtask : t_stretch
  task automatic hstep(input logic c, input logic d);
    @(posedge clk) begin
      ms <= !c;
      md <= !d;
    end
    repeat (19) @(posedge clk);
  endtask : hstep
  task automatic t_gcall(input logic [3:0] m, input logic g,
                         input logic [7:0] b, input logic e);
    logic a;
    @(posedge clk) {mode, gce, on} <= {m, g, 1'h0};
    repeat (16) @(posedge clk);
    pulse(7);
    hstep(1'h1, 1'h1);
    hstep(1'h1, 1'h0);
    for (int i = 7; i >= 0; i--) begin
      hstep(1'h0, b[i]);
      hstep(1'h1, b[i]);
    end
    hstep(1'h0, 1'h1);
    hstep(1'h1, 1'h1);
    a = sda;
    hstep(1'h0, 1'h0);
    hstep(1'h1, 1'h0);
    hstep(1'h1, 1'h1);
    chk(a, !e);
    chk(intf, e);
    chk(ua, m == 4'h7 && b != 8'h00);
    if (e) begin
      chk(buf_o, b);
      chk(full, 1'h1);
    end
    pulse(6);
    pulse(9);
    $display("address test done");
  endtask : t_gcall
  task automatic final_report;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  initial begin
    #200000;
    n_mismatch++;
    final_report;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    t_master;
    t_stretch;
    t_gcall(4'h6, 1'h1, 8'h00, 1'h1);
    t_gcall(4'h7, 1'h1, 8'h00, 1'h1);
    t_gcall(4'h6, 1'h0, 8'h00, 1'h0);
    t_gcall(4'h6, 1'h0, 8'h08, 1'h1);
    t_gcall(4'h7, 1'h0, 8'h08, 1'h1);
    final_report;
  end
endmodule : i2cm_core_tb
